// ### rtl/tsl_torque_speed_limit_unit.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
// Behaviour
// - always cap torque by forward/reverse limits
// - limits are 0.1 percent of rated torque
// - forward limits positive torque, reverse negative
// - all three limits zero gives zero torque
// - never exceed the motor's own maximum torque
// - select 0 ignores max cap, reads motor max
// - swap limit objects when reflect 0, direction 1
// - torque limiting flag and status bit 13
// - speed cap only in torque modes
// - speed cap only in torque command direction
// - speed cap resets to 3000.00, is object
// - unit select 1 uses extension speed cap
// - speed limiting flag and status bit 4
// - no degree positioning in cyclic synchronous modes
// - alarm 037 on degree with linear motor
// - alarm 037 on degree, closed loop, linear encoder
// - relative start with degree raises warning, no move
// - controller writes override software writes
// - degree position reported 0 to 359999
module tsl_torque_speed_limit_unit
    import tsl_pkg::*;
#(
    parameter int TW = 16                           // torque word width, 0.1 % units
) (
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    // apb slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic                       pready_out,
    output logic [31:0]                prdata_out,
    output logic                       pslverr_out,
    // cyclic object writes from the motion controller
    input  wire tsl_obj_wr_type        obj_wr_in,
    // servo core side
    input  wire tsl_drive_cfg_type     drive_cfg_in,
    input  wire logic [TW-1:0]         motor_max_torque_in,
    input  wire logic signed [TW-1:0]  torque_cmd_in,
    input  wire logic signed [TW-1:0]  motor_torque_in,
    input  wire logic signed [31:0]    motor_speed_in,
    input  wire logic signed [31:0]    position_raw_in,
    input  wire logic                  pos_start_in,
    input  wire logic                  ctrl_relative_in,
    output logic signed [TW-1:0]       torque_ref_out,
    output logic                       torque_limiting_flag_out,
    output logic                       speed_limiting_flag_out,
    output logic [15:0]                status_do1_out,
    output logic [15:0]                status_do2_out,
    output logic                       alarm_037_out,
    output logic                       warning_0f48_out,
    output logic                       pos_start_accept_out,
    output logic [31:0]                position_actual_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // setting registers

    logic [TW-1:0] forward_torque_cap_param_ff;    // forward cap setting
    logic [TW-1:0] reverse_torque_cap_param_ff;    // reverse cap setting
    logic [TW-1:0] max_torque_cap_one_param_ff;    // max cap one setting
    logic [31:0]   torque_mode_speed_cap_param_ff; // speed cap setting
    logic [31:0]   speed_cap_extension_param_ff;   // extension speed cap
    logic [4:0]    config_ff;                      // selection bits
    logic [4:0]    map_mask_ff;                    // controller-owned settings
    logic          warning_ff;                     // sticky warning 0f4.8

    logic          apb_wr;                         // write access phase
    logic          apb_setup;                      // setup phase, read data prepared here

    assign apb_wr    = psel_in && penable_in && pwrite_in;
    assign apb_setup = psel_in && !penable_in;
    // zero wait: the access phase always completes
    assign pready_out = 1'b1;

    // software may write a setting only while the controller does not own it
    function automatic logic sw_may_write(input logic [7:0] ofs, input logic [7:0] want, input logic owned);
        sw_may_write = apb_wr && (ofs == want) && !owned;
    endfunction

    // cyclic write from the controller for one setting
    function automatic logic ctrl_writes(input tsl_obj_sel_type sel);
        ctrl_writes = obj_wr_in.valid && (obj_wr_in.sel == sel);
    endfunction

    // forward cap: controller value wins in the same cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            forward_torque_cap_param_ff <= TSL_RST_TORQUE_CAP;
        end else if (ctrl_writes(TSL_OBJ_FWD_CAP)) begin
            forward_torque_cap_param_ff <= obj_wr_in.data[TW-1:0];
        end else if (sw_may_write(paddr_in, TSL_OFS_FWD_CAP, map_mask_ff[0])) begin
            forward_torque_cap_param_ff <= pwdata_in[TW-1:0];
        end
    end

    // reverse cap
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reverse_torque_cap_param_ff <= TSL_RST_TORQUE_CAP;
        end else if (ctrl_writes(TSL_OBJ_REV_CAP)) begin
            reverse_torque_cap_param_ff <= obj_wr_in.data[TW-1:0];
        end else if (sw_may_write(paddr_in, TSL_OFS_REV_CAP, map_mask_ff[1])) begin
            reverse_torque_cap_param_ff <= pwdata_in[TW-1:0];
        end
    end

    // max cap one
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            max_torque_cap_one_param_ff <= TSL_RST_TORQUE_CAP;
        end else if (ctrl_writes(TSL_OBJ_MAX_CAP)) begin
            max_torque_cap_one_param_ff <= obj_wr_in.data[TW-1:0];
        end else if (sw_may_write(paddr_in, TSL_OFS_MAX_CAP, map_mask_ff[2])) begin
            max_torque_cap_one_param_ff <= pwdata_in[TW-1:0];
        end
    end

    // torque mode speed cap, reset 3000.00
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            torque_mode_speed_cap_param_ff <= TSL_RST_SPD_CAP;
        end else if (ctrl_writes(TSL_OBJ_SPD_CAP)) begin
            torque_mode_speed_cap_param_ff <= obj_wr_in.data;
        end else if (sw_may_write(paddr_in, TSL_OFS_SPD_CAP, map_mask_ff[3])) begin
            torque_mode_speed_cap_param_ff <= pwdata_in;
        end
    end

    // speed cap extension, reset 2147483647
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            speed_cap_extension_param_ff <= TSL_RST_SPD_EXT;
        end else if (ctrl_writes(TSL_OBJ_SPD_EXT)) begin
            speed_cap_extension_param_ff <= obj_wr_in.data;
        end else if (sw_may_write(paddr_in, TSL_OFS_SPD_EXT, map_mask_ff[4])) begin
            speed_cap_extension_param_ff <= pwdata_in;
        end
    end

    // config and map mask are software only
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            config_ff   <= TSL_RST_CONFIG;
            map_mask_ff <= TSL_RST_MAP_MASK;
        end else if (apb_wr && paddr_in == TSL_OFS_CONFIG) begin
            config_ff   <= pwdata_in[4:0];
        end else if (apb_wr && paddr_in == TSL_OFS_MAP_MASK) begin
            map_mask_ff <= pwdata_in[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // torque limit selection

    logic          max_sel;        // max cap one enabled
    logic          swap_objects;   // objects exchanged by direction setting
    logic [TW-1:0] pos_cap;        // cap for positive torque
    logic [TW-1:0] neg_cap;        // cap for negative torque
    logic [TW-1:0] max_obj;        // max torque object readback
    logic [TW-1:0] pos_obj;        // positive limit object
    logic [TW-1:0] neg_obj;        // negative limit object

    assign max_sel      = config_ff[TSL_CFG_MAX_SEL];
    // table: reflection 0 means enabled, so only then does direction 1 swap
    assign swap_objects = !config_ff[TSL_CFG_POL_REFLECT] && config_ff[TSL_CFG_TRAVEL_DIR];
    assign pos_obj      = swap_objects ? reverse_torque_cap_param_ff : forward_torque_cap_param_ff;
    assign neg_obj      = swap_objects ? forward_torque_cap_param_ff : reverse_torque_cap_param_ff;

    function automatic logic [TW-1:0] min2(input logic [TW-1:0] a, input logic [TW-1:0] b);
        min2 = (a < b) ? a : b;
    endfunction

    // combine each direction cap with motor max and optional max cap one
    always_comb begin
        // motor max bounds every setting, in 0.1 % of rating like the caps
        pos_cap = min2(forward_torque_cap_param_ff, motor_max_torque_in);
        neg_cap = min2(reverse_torque_cap_param_ff, motor_max_torque_in);
        if (max_sel) begin
            pos_cap = min2(pos_cap, max_torque_cap_one_param_ff);
            neg_cap = min2(neg_cap, max_torque_cap_one_param_ff);
            max_obj = max_torque_cap_one_param_ff;
        end else begin
            max_obj = motor_max_torque_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // speed limit

    logic               torque_mode;   // profile torque or cyclic torque
    logic signed [32:0] spd_cap;       // active speed cap, one extra sign bit
    logic               spd_hit;       // speed reached in command direction

    assign torque_mode = (drive_cfg_in.mode == TSL_MODE_TQ) || (drive_cfg_in.mode == TSL_MODE_CST);
    assign spd_cap     = config_ff[TSL_CFG_SPD_UNIT] ? {1'b0, speed_cap_extension_param_ff}
                                                     : {1'b0, torque_mode_speed_cap_param_ff};

    // only the direction the torque drives is watched; reversing stays free
    always_comb begin
        spd_hit = 1'b0;
        if (torque_mode) begin
            if (torque_cmd_in > 0) begin
                spd_hit = 33'(motor_speed_in) >= spd_cap;
            end else if (torque_cmd_in < 0) begin
                spd_hit = -33'(motor_speed_in) >= spd_cap;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // limited torque reference and flags

    logic signed [TW:0] cmd_wide;      // command with headroom for negation
    logic signed [TW:0] lim_wide;      // clamped command
    logic               trq_hit;       // motor torque at its active cap

    assign cmd_wide = (TW+1)'(torque_cmd_in);

    // clamp, and cut drive torque at the speed cap; all caps zero leave zero
    always_comb begin
        lim_wide = cmd_wide;
        if (cmd_wide > $signed({1'b0, pos_cap})) begin
            lim_wide = $signed({1'b0, pos_cap});
        end else if (cmd_wide < -$signed({1'b0, neg_cap})) begin
            lim_wide = -$signed({1'b0, neg_cap});
        end
        if (spd_hit) begin
            lim_wide = '0;
        end
    end

    // compare actual torque against the cap of its own sign
    always_comb begin
        if (motor_torque_in >= 0) begin
            trq_hit = (TW+1)'(motor_torque_in) >= $signed({1'b0, pos_cap});
        end else begin
            trq_hit = -(TW+1)'(motor_torque_in) >= $signed({1'b0, neg_cap});
        end
    end

    // outputs registered, so flags drop one edge after the value falls
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            torque_ref_out           <= '0;
            torque_limiting_flag_out <= 1'b0;
            speed_limiting_flag_out  <= 1'b0;
        end else begin
            torque_ref_out           <= lim_wide[TW-1:0];
            torque_limiting_flag_out <= trq_hit;
            speed_limiting_flag_out  <= spd_hit;
        end
    end

    assign status_do1_out = 16'(torque_limiting_flag_out) << TSL_DO1_TORQUE_BIT;
    assign status_do2_out = 16'(speed_limiting_flag_out) << TSL_DO2_SPEED_BIT;

    ////////////////////////////////////////////////////////////////////////////////
    // degree unit checks

    logic deg_en;      // degree unit requested
    logic cyclic_mode; // cyclic synchronous modes
    logic deg_active;  // degree positioning in effect
    logic alarm_now;   // configuration conflict

    assign deg_en      = config_ff[TSL_CFG_DEG_EN];
    assign cyclic_mode = drive_cfg_in.mode inside {TSL_MODE_CSP, TSL_MODE_CSV, TSL_MODE_CST};
    assign deg_active  = deg_en && !cyclic_mode && !alarm_now;
    assign alarm_now   = deg_en && (drive_cfg_in.linear_motor
                         || (drive_cfg_in.fully_closed && drive_cfg_in.linear_load_enc));

    // alarm follows the configuration as a level
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_037_out <= 1'b0;
        end else begin
            alarm_037_out <= alarm_now;
        end
    end

    logic rel_block;   // relative start refused

    assign rel_block = pos_start_in && deg_active && (drive_cfg_in.mode == TSL_MODE_PP) && ctrl_relative_in;

    // warning is sticky; a new refusal beats a clear in the same cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            warning_ff <= 1'b0;
        end else if (rel_block) begin
            warning_ff <= 1'b1;
        end else if (apb_wr && paddr_in == TSL_OFS_STATUS && pwdata_in[TSL_ST_WARN_0F48]) begin
            warning_ff <= 1'b0;
        end
    end

    assign warning_0f48_out = warning_ff;

    // start passes on one cycle later unless refused
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pos_start_accept_out <= 1'b0;
        end else begin
            pos_start_accept_out <= pos_start_in && !rel_block;
        end
    end

    // modulo position; the divider is wide and always computes, its result is used only when degree is active
    logic signed [31:0] pos_rem;   // signed remainder

    assign pos_rem = position_raw_in % TSL_DEG_MODULO;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            position_actual_out <= '0;
        end else if (!deg_active) begin
            position_actual_out <= position_raw_in;
        end else if (pos_rem < 0) begin
            position_actual_out <= pos_rem + TSL_DEG_MODULO;
        end else begin
            position_actual_out <= pos_rem;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb read path

    logic [31:0] rd_data;   // selected read word
    logic        rd_err;    // unmapped address

    // address decode
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (paddr_in == TSL_OFS_FWD_CAP) begin
            rd_data = 32'(forward_torque_cap_param_ff);
        end else if (paddr_in == TSL_OFS_REV_CAP) begin
            rd_data = 32'(reverse_torque_cap_param_ff);
        end else if (paddr_in == TSL_OFS_MAX_CAP) begin
            rd_data = 32'(max_torque_cap_one_param_ff);
        end else if (paddr_in == TSL_OFS_CONFIG) begin
            rd_data = 32'(config_ff);
        end else if (paddr_in == TSL_OFS_SPD_CAP) begin
            rd_data = torque_mode_speed_cap_param_ff;
        end else if (paddr_in == TSL_OFS_SPD_EXT) begin
            rd_data = speed_cap_extension_param_ff;
        end else if (paddr_in == TSL_OFS_STATUS) begin
            rd_data = 32'({deg_active, warning_ff, alarm_037_out,
                           speed_limiting_flag_out, torque_limiting_flag_out});
        end else if (paddr_in == TSL_OFS_POS_OBJ) begin
            rd_data = 32'(pos_obj);
        end else if (paddr_in == TSL_OFS_NEG_OBJ) begin
            rd_data = 32'(neg_obj);
        end else if (paddr_in == TSL_OFS_MAX_OBJ) begin
            rd_data = 32'(max_obj);
        end else if (paddr_in == TSL_OFS_MAP_MASK) begin
            rd_data = 32'(map_mask_ff);
        end else begin
            rd_err  = 1'b1;
        end
    end

    // data captured in setup, stands through the access cycle
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else if (apb_setup) begin
            prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_data;
            pslverr_out <= rd_err;
        end
    end

endmodule

// ### rtl/tsl_pkg.sv
package tsl_pkg;

    // apb register byte offsets
    localparam logic [7:0] TSL_OFS_FWD_CAP   = 8'h00; // forward torque cap, 0.1 %
    localparam logic [7:0] TSL_OFS_REV_CAP   = 8'h04; // reverse torque cap, 0.1 %
    localparam logic [7:0] TSL_OFS_MAX_CAP   = 8'h08; // max torque cap one, 0.1 %
    localparam logic [7:0] TSL_OFS_CONFIG    = 8'h0c; // selection bits
    localparam logic [7:0] TSL_OFS_SPD_CAP   = 8'h10; // torque mode speed cap, 0.01 r/min
    localparam logic [7:0] TSL_OFS_SPD_EXT   = 8'h14; // speed cap extension, command unit/s
    localparam logic [7:0] TSL_OFS_STATUS    = 8'h18; // flags, write one to clear warning
    localparam logic [7:0] TSL_OFS_POS_OBJ   = 8'h1c; // positive limit object, read only
    localparam logic [7:0] TSL_OFS_NEG_OBJ   = 8'h20; // negative limit object, read only
    localparam logic [7:0] TSL_OFS_MAX_OBJ   = 8'h24; // max torque object, read only
    localparam logic [7:0] TSL_OFS_MAP_MASK  = 8'h28; // which settings the controller owns

    // config field positions
    localparam int TSL_CFG_MAX_SEL     = 0;
    localparam int TSL_CFG_POL_REFLECT = 1;
    localparam int TSL_CFG_TRAVEL_DIR  = 2;
    localparam int TSL_CFG_SPD_UNIT    = 3;
    localparam int TSL_CFG_DEG_EN      = 4;

    // status field positions
    localparam int TSL_ST_TORQUE_LIM   = 0;
    localparam int TSL_ST_SPEED_LIM    = 1;
    localparam int TSL_ST_ALARM_037    = 2;
    localparam int TSL_ST_WARN_0F48    = 3;
    localparam int TSL_ST_DEG_ACTIVE   = 4;

    // digital status object bit positions
    localparam int TSL_DO1_TORQUE_BIT  = 13;
    localparam int TSL_DO2_SPEED_BIT   = 4;

    // reset values
    localparam logic [15:0] TSL_RST_TORQUE_CAP = 16'h03e8;      // 100.0 % of rating
    localparam logic [31:0] TSL_RST_SPD_CAP    = 32'h000493e0;  // 3000.00 r/min
    localparam logic [31:0] TSL_RST_SPD_EXT    = 32'h7fffffff;  // 2147483647
    localparam logic [4:0]  TSL_RST_CONFIG     = 5'h00;
    localparam logic [4:0]  TSL_RST_MAP_MASK   = 5'h00;

    // degree unit modulo, 0.001 degree steps
    localparam logic signed [31:0] TSL_DEG_MODULO = 32'sh00057e40; // 360000

    // control modes
    typedef enum logic [3:0] {
        TSL_MODE_NONE = 4'b0000,
        TSL_MODE_PP   = 4'b0001,
        TSL_MODE_PV   = 4'b0011,
        TSL_MODE_TQ   = 4'b0100,
        TSL_MODE_HM   = 4'b0110,
        TSL_MODE_CSP  = 4'b1000,
        TSL_MODE_CSV  = 4'b1001,
        TSL_MODE_CST  = 4'b1010
    } tsl_mode_type;

    // settings the controller can write cyclically
    typedef enum logic [2:0] {
        TSL_OBJ_FWD_CAP = 3'b000,
        TSL_OBJ_REV_CAP = 3'b001,
        TSL_OBJ_MAX_CAP = 3'b010,
        TSL_OBJ_SPD_CAP = 3'b011,
        TSL_OBJ_SPD_EXT = 3'b100
    } tsl_obj_sel_type;

    // one cyclic object write from the controller
    typedef struct packed {
        logic            valid;
        tsl_obj_sel_type sel;
        logic [31:0]     data;
    } tsl_obj_wr_type;

    // drive situation supplied by the servo core
    typedef struct packed {
        tsl_mode_type mode;
        logic         linear_motor;
        logic         fully_closed;
        logic         linear_load_enc;
    } tsl_drive_cfg_type;

endpackage

// ### tb/tsl_limit_asserts.sv
`timescale 1ns/1ps
module tsl_limit_asserts
    import tsl_pkg::*;
#(
    parameter int TW = 16 // torque word width
) (
    input wire logic                 clock_in,
    input wire logic                 rst_in,
    input wire logic                 pready_out,
    input wire logic [15:0]          status_do1_out,
    input wire logic [15:0]          status_do2_out,
    input wire logic                 torque_limiting_flag_out,
    input wire logic                 speed_limiting_flag_out,
    input wire logic [TW-1:0]        motor_max_torque_in,
    input wire logic signed [TW-1:0] torque_cmd_in,
    input wire logic signed [TW-1:0] torque_ref_out,
    input wire logic                 pos_start_in,
    input wire logic                 ctrl_relative_in,
    input wire logic                 pos_start_accept_out,
    input wire logic                 warning_0f48_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    // start kinds, told apart by the relative bit
    sequence s_abs; pos_start_in && !ctrl_relative_in; endsequence
    sequence s_rel; pos_start_in && ctrl_relative_in; endsequence
    ////////////////////////////////////////
    a_ready_tied: assert property (pready_out) else $error("ready low");
    a_torque_bit: assert property (status_do1_out[13] == torque_limiting_flag_out)
        else $error("do1 bit wrong");
    a_speed_bit: assert property (status_do2_out[4] == speed_limiting_flag_out)
        else $error("do2 bit wrong");
    // 17 bit compare, so the most negative word cannot wrap
    a_ref_motor_max: assert property (torque_ref_out <= $signed({1'b0, $past(motor_max_torque_in)})
        && -torque_ref_out <= $signed({1'b0, $past(motor_max_torque_in)})) else $error("above motor max");
    a_ref_sign: assert property (torque_ref_out == 0 || torque_ref_out[TW-1] == $past(torque_cmd_in[TW-1]))
        else $error("ref sign flipped");
    a_abs_accept: assert property (s_abs |=> pos_start_accept_out) else $error("start lost");
    a_rel_answer: assert property (s_rel |=> pos_start_accept_out || warning_0f48_out)
        else $error("start unanswered");
    a_refused_still: assert property ($rose(warning_0f48_out) |-> !pos_start_accept_out)
        else $error("refused start moved");
    a_accept_cause: assert property (pos_start_accept_out |-> $past(pos_start_in))
        else $error("accept uncaused");
endmodule
bind tsl_torque_speed_limit_unit tsl_limit_asserts #(.TW(TW)) i_tsl_limit_asserts (.*);

// ### tb/tsl_ctrl_model.sv
`timescale 1ns/1ps
module tsl_ctrl_model
    import tsl_pkg::*;
(
    input  wire logic      clock_in,
    output tsl_obj_wr_type obj_wr_out
);
    // quiet at start
    initial obj_wr_out = '0;
    // one object write, valid for one cycle; idle data inverted so it is never stale
    task automatic send(input tsl_obj_sel_type sel, input logic [31:0] data);
        @(posedge clock_in);
        obj_wr_out <= '{1'b1, sel, data};
        @(posedge clock_in);
        obj_wr_out <= '{1'b0, sel, ~data};
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tsl_pkg::*;
    ////////////////////////////////////////
    logic clock_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out; // bus
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, position_actual_out, rd; // words
    logic [15:0] motor_max_torque_in, status_do1_out, status_do2_out;
    logic signed [15:0] torque_cmd_in, motor_torque_in, torque_ref_out; // 0.1 %
    logic signed [31:0] motor_speed_in, position_raw_in;
    logic pos_start_in, ctrl_relative_in, pos_start_accept_out, alarm_037_out, warning_0f48_out;
    logic torque_limiting_flag_out, speed_limiting_flag_out;
    tsl_obj_wr_type obj_wr_in; // from the controller model
    tsl_drive_cfg_type drive_cfg_in;
    int errors, comparisons, cycles;
    tsl_torque_speed_limit_unit i_tsl_torque_speed_limit_unit (.*);
    tsl_ctrl_model i_tsl_ctrl_model (.clock_in(clock_in), .obj_wr_out(obj_wr_in));
    ////////////////////////////////////////
    // 40 ns clock
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // hang guard, well above the run length
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one apb transfer; read data lands in rd
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= data;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // let the one cycle latency land
    task automatic settle;
        repeat (2) @(posedge clock_in);
    endtask
    task automatic run(input logic signed [15:0] cmd, input logic signed [15:0] exp);
        torque_cmd_in <= cmd;
        settle();
        check({16'h0, torque_ref_out}, {16'h0, exp});
    endtask
    task automatic pulse;
        @(posedge clock_in);
        pos_start_in <= 1'b1;
        @(posedge clock_in);
        pos_start_in <= 1'b0;
        @(posedge clock_in);
    endtask
    ////////////////////////////////////////
    initial begin
        {rst_in, psel_in, penable_in, pwrite_in, pos_start_in, ctrl_relative_in} = 6'h20;
        {paddr_in, pwdata_in, torque_cmd_in, motor_torque_in, motor_speed_in, position_raw_in} = '0;
        motor_max_torque_in = 16'h7fff;
        drive_cfg_in = '{TSL_MODE_PV, 1'b0, 1'b0, 1'b0};
        {errors, comparisons, cycles} = '0;
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        apb(1'b0, TSL_OFS_FWD_CAP, 0);
        check(rd, 32'h3e8);
        apb(1'b0, TSL_OFS_SPD_CAP, 0);
        check(rd, 32'h000493e0);
        apb(1'b0, TSL_OFS_SPD_EXT, 0);
        check(rd, 32'h7fffffff);
        apb(1'b0, 8'h2c, 0);
        check({rd[30:0], pslverr_out}, 32'h1);
        apb(1'b1, TSL_OFS_FWD_CAP, 32'h64);
        apb(1'b1, TSL_OFS_REV_CAP, 32'hc8);
        run(16'sd500, 16'sd100);
        run(-16'sd500, -16'sd200);
        motor_torque_in <= -16'sd200;
        settle();
        check({31'h0, torque_limiting_flag_out}, 32'h1);
        motor_torque_in <= -16'sd150;
        settle();
        check({31'h0, torque_limiting_flag_out}, 32'h0);
        motor_max_torque_in <= 16'h0050;
        run(16'sd500, 16'sd80);
        motor_max_torque_in <= 16'h7fff;
        apb(1'b0, TSL_OFS_MAX_OBJ, 0);
        check(rd, 32'h7fff);
        apb(1'b1, TSL_OFS_MAX_CAP, 32'h32);
        run(16'sd500, 16'sd100);
        apb(1'b1, TSL_OFS_CONFIG, 32'h1);
        run(16'sd500, 16'sd50);
        apb(1'b1, TSL_OFS_FWD_CAP, 32'h0);
        apb(1'b1, TSL_OFS_REV_CAP, 32'h0);
        apb(1'b1, TSL_OFS_MAX_CAP, 32'h0);
        run(-16'sd500, 16'sd0);
        apb(1'b1, TSL_OFS_FWD_CAP, 32'h64);
        apb(1'b1, TSL_OFS_REV_CAP, 32'hc8);
        // all reflect and direction pairs; only reflect 0 with direction 1 swaps
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, TSL_OFS_CONFIG, 32'(i * 2));
            apb(1'b0, TSL_OFS_POS_OBJ, 0);
            check(rd, (i == 2) ? 32'hc8 : 32'h64);
        end
        apb(1'b1, TSL_OFS_CONFIG, 32'h0);
        apb(1'b1, TSL_OFS_SPD_CAP, 32'd1000);
        drive_cfg_in.mode <= TSL_MODE_TQ;
        motor_speed_in <= 32'sd1000;
        run(16'sd500, 16'sd0);
        check({31'h0, status_do2_out[4]}, 32'h1);
        motor_speed_in <= -32'sd1000;
        run(16'sd500, 16'sd100);
        apb(1'b1, TSL_OFS_CONFIG, 32'h8);
        apb(1'b1, TSL_OFS_SPD_EXT, 32'd500);
        run(-16'sd500, 16'sd0);
        drive_cfg_in.mode <= TSL_MODE_PV;
        run(-16'sd500, -16'sd200);
        i_tsl_ctrl_model.send(TSL_OBJ_FWD_CAP, 32'h1f4);
        apb(1'b1, TSL_OFS_MAP_MASK, 32'h1);
        apb(1'b1, TSL_OFS_FWD_CAP, 32'h10);
        apb(1'b0, TSL_OFS_FWD_CAP, 0);
        check(rd, 32'h1f4);
        apb(1'b1, TSL_OFS_CONFIG, 32'h10);
        drive_cfg_in.mode <= TSL_MODE_PP;
        position_raw_in <= -32'sd1000;
        settle();
        check(position_actual_out, 32'h00057a58);
        drive_cfg_in.linear_motor <= 1'b1;
        settle();
        check({31'h0, alarm_037_out}, 32'h1);
        drive_cfg_in.linear_motor <= 1'b0;
        pulse();
        check({30'h0, pos_start_accept_out, warning_0f48_out}, 32'h2);
        ctrl_relative_in <= 1'b1;
        pulse();
        check({30'h0, pos_start_accept_out, warning_0f48_out}, 32'h1);
        give_verdict();
    end
endmodule
